/* inc/adcoc_regs.vh */
`ifndef ADCOC_REGS_VH
`define ADCOC_REGS_VH
// register addresses (7-bit)
`define ADCOC_ADDR_RESET      7'h00
`define ADCOC_ADDR_TIMING     7'h02
`define ADCOC_ADDR_MODE       7'h03
`define ADCOC_ADDR_FORMAT     7'h04
// software reset bit in the reset register
`define ADCOC_RESET_BIT       7
// writable masks
`define ADCOC_TIMING_MASK     8'h0F
`define ADCOC_MODE_MASK       8'h7F
`define ADCOC_FORMAT_MASK     8'h3F
`define ADCOC_REG_RESET       8'h00
// timing register fields
`define ADCOC_T_DCS           0
`define ADCOC_T_PH_LO         1
`define ADCOC_T_PH_HI         2
`define ADCOC_T_POL           3
// mode register fields
`define ADCOC_M_FMT_LO        0
`define ADCOC_M_FMT_HI        1
`define ADCOC_M_OFF           2
`define ADCOC_M_TERM          3
`define ADCOC_M_CUR_LO        4
`define ADCOC_M_CUR_HI        6
// format register fields
`define ADCOC_F_SIGNED        0
`define ADCOC_F_OUTPUT_RANDOMIZER_ON          1
`define ADCOC_F_ABP           2
`define ADCOC_F_TP_LO         3
`define ADCOC_F_TP_HI         5
// output formats
`define ADCOC_FMT_CMOS        2'h0
`define ADCOC_FMT_LVDS        2'h1
`define ADCOC_FMT_DDRCMOS     2'h2
// test patterns
`define ADCOC_TP_OFF          3'h0
`define ADCOC_TP_ZERO         3'h1
`define ADCOC_TP_ONE          3'h3
`define ADCOC_TP_CHECK        3'h5
`define ADCOC_TP_ALT          3'h7
`define ADCOC_CHECK_A         17'h15555
`define ADCOC_CHECK_B         17'h0AAAA
// serial word
`define ADCOC_WORD_BITS       16
`endif

/* rtl/adcoc_fifo.v */
`timescale 1ns/1ns
module adcoc_fifo #(
    parameter WIDTH = 17,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    // clock and reset
    input  wire             clk_in,
    input  wire             rst_in,
    input  wire             ce_in,
    // fill side
    input  wire             in_valid_in,
    output wire             in_ready_out,
    input  wire [WIDTH-1:0] in_data_in,
    // drain side
    output wire             out_valid_out,
    input  wire             out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;
    reg             ready_reg;
    integer         i;
    localparam [AW:0] LAST_CNT = DEPTH - 1;

    // ready comes from a flop so the fill side never sees a compare glitch
    assign in_ready_out  = ready_reg;
    assign out_valid_out = (count_reg != {(AW+1){1'b0}});
    assign out_data_out  = mem_reg[rd_ptr_reg];
    assign push          = ce_in & in_valid_in & in_ready_out;
    assign pop           = ce_in & out_valid_out & out_ready_in;

    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
            ready_reg  <= 1'b1;
            for (i = 0; i < DEPTH; i = i + 1)
                mem_reg[i] <= {WIDTH{1'b0}};
        end else begin
            if (push) begin
                mem_reg[wr_ptr_reg] <= in_data_in;
                wr_ptr_reg          <= wr_ptr_reg + 1'b1;
            end
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push & ~pop) begin
                count_reg <= count_reg + 1'b1;
                ready_reg <= (count_reg != LAST_CNT);
            end else if (pop & ~push) begin
                count_reg <= count_reg - 1'b1;
                ready_reg <= 1'b1;
            end
        end
    end
endmodule // adcoc_fifo

/* rtl/adcoc_regs.v */
`timescale 1ns/1ns
`include "adcoc_regs.vh"
module adcoc_regs #(
    parameter DATA_W     = 16,
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW    = 2
) (
    // clock and reset
    input  wire              ref_clk_in,
    input  wire              sys_rst_in,
    input  wire              clk_en_in,
    // serial port pins (async to ref_clk_in)
    input  wire              ser_cs_n_in,
    input  wire              ser_clk_in,
    input  wire              ser_data_in,
    output reg               ser_data_out,
    output reg               ser_data_oe_n_out,
    // converter samples
    input  wire              smp_valid_in,
    output wire              smp_ready_out,
    input  wire [DATA_W-1:0] smp_data_in,
    input  wire              smp_overrange_in,
    // processed sample stream to output drivers
    output reg               out_valid_out,
    input  wire              out_ready_in,
    output reg  [DATA_W-1:0] out_data_out,
    output reg               overrange_flag_out,
    output reg               out_data_oe_n_out,
    // driver configuration
    output reg               output_clock_out,
    output reg  [1:0]        out_clock_delay_out,
    output reg               duty_cycle_stabilizer_on_out,
    output reg  [1:0]        output_format_sel_out,
    output reg  [3:0]        drive_current_code_out,
    output reg               internal_termination_enable_out,
    output reg               alternate_bit_polarity_out,
    output reg               output_randomizer_on_out
);
    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    reg [1:0]  cs_sync_reg;
    reg [1:0]  sck_sync_reg;
    reg [1:0]  sdi_sync_reg;
    reg        sck_prev_reg;
    wire       cs_n;
    wire       sck;
    wire       sdi;
    wire       sck_rise;
    wire       sck_fall;

    always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cs_sync_reg  <= 2'h3;
            sck_sync_reg <= 2'h0;
            sdi_sync_reg <= 2'h0;
            sck_prev_reg <= 1'b0;
        end else if (clk_en_in) begin
            cs_sync_reg  <= {cs_sync_reg[0], ser_cs_n_in};
            sck_sync_reg <= {sck_sync_reg[0], ser_clk_in};
            sdi_sync_reg <= {sdi_sync_reg[0], ser_data_in};
            sck_prev_reg <= sck_sync_reg[1];
        end
    end

    assign cs_n     = cs_sync_reg[1];
    assign sck      = sck_sync_reg[1];
    assign sdi      = sdi_sync_reg[1];
    assign sck_rise = sck & ~sck_prev_reg;
    assign sck_fall = ~sck & sck_prev_reg;

    ////////////////////////////////////////////////////////////////////
    // serial shifter
    localparam ST_IDLE = 3'h1;
    localparam ST_SHIFT = 3'h2;
    localparam ST_DONE = 3'h4;

    reg [2:0]  state_reg;
    reg [15:0] shift_reg;
    reg [4:0]  bit_cnt_reg;
    reg [7:0]  rd_shift_reg;
    reg [7:0]  timing_reg;
    reg [7:0]  mode_reg;
    reg [7:0]  format_reg;
    reg [7:0]  rd_value;
    wire [15:0] word_next;
    wire       word_done;
    reg        rd_cmd_reg;

    assign word_next = {shift_reg[14:0], sdi};
    assign word_done = (bit_cnt_reg == 5'h0F) & sck_rise;

    // at the eighth rise the address sits in the low seven bits
    always @* begin
        case (word_next[6:0])
            `ADCOC_ADDR_TIMING: rd_value = timing_reg;
            `ADCOC_ADDR_MODE:   rd_value = mode_reg;
            `ADCOC_ADDR_FORMAT: rd_value = format_reg;
            default:            rd_value = 8'h00;
        endcase
    end

    always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_reg         <= ST_IDLE;
            shift_reg         <= 16'h0000;
            bit_cnt_reg       <= 5'h00;
            rd_shift_reg      <= 8'h00;
            rd_cmd_reg        <= 1'b0;
            ser_data_out      <= 1'b1;
            ser_data_oe_n_out <= 1'b1;
            timing_reg        <= `ADCOC_REG_RESET;
            mode_reg          <= `ADCOC_REG_RESET;
            format_reg        <= `ADCOC_REG_RESET;
        end else if (clk_en_in) begin
            case (state_reg)
                ST_IDLE: begin
                    ser_data_oe_n_out <= 1'b1;
                    bit_cnt_reg       <= 5'h00;
                    rd_cmd_reg        <= 1'b0;
                    if (!cs_n)
                        state_reg <= ST_SHIFT;
                end
                ST_SHIFT: begin
                    if (cs_n) begin
                        // cut frame: let go of the line at once
                        state_reg         <= ST_IDLE;
                        ser_data_oe_n_out <= 1'b1;
                    end else if (sck_rise) begin
                        shift_reg   <= word_next;
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                        // read flag is word bit 15; address follows
                        if (bit_cnt_reg == 5'h07)
                            rd_cmd_reg <= word_next[7];
                        if (bit_cnt_reg == 5'h07 && word_next[7]) begin
                            rd_shift_reg      <= rd_value;
                            ser_data_oe_n_out <= 1'b1;
                        end
                        if (word_done) begin
                            state_reg <= ST_DONE;
                            if (!word_next[15]) begin
                                case (word_next[14:8])
                                    `ADCOC_ADDR_RESET:
                                        if (word_next[`ADCOC_RESET_BIT])
                                        begin
                                            timing_reg <= `ADCOC_REG_RESET;
                                            mode_reg   <= `ADCOC_REG_RESET;
                                            format_reg <= `ADCOC_REG_RESET;
                                        end
                                    `ADCOC_ADDR_TIMING:
                                        timing_reg <= word_next[7:0]
                                            & `ADCOC_TIMING_MASK;
                                    `ADCOC_ADDR_MODE:
                                        mode_reg <= word_next[7:0]
                                            & `ADCOC_MODE_MASK;
                                    `ADCOC_ADDR_FORMAT:
                                        format_reg <= word_next[7:0]
                                            & `ADCOC_FORMAT_MASK;
                                    default: ;
                                endcase
                            end
                        end
                    end else if (sck_fall && bit_cnt_reg >= 5'h08
                                 && rd_cmd_reg) begin
                        // open drain: only low bits are driven
                        ser_data_oe_n_out <= rd_shift_reg[7];
                        ser_data_out      <= 1'b0;
                        rd_shift_reg      <= {rd_shift_reg[6:0], 1'b0};
                    end
                end
                ST_DONE: begin
                    // later edges ignored until select rises
                    ser_data_oe_n_out <= 1'b1;
                    if (cs_n)
                        state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sample path: fifo then formatter
    wire              f_valid;
    wire              f_ready;
    wire [DATA_W:0]   f_data;
    reg               alt_reg;
    reg  [DATA_W-1:0] lfsr_reg;
    reg  [DATA_W:0]   pat;
    reg  [DATA_W-1:0] coded;
    wire [2:0]        tp_sel;
    wire              signed_sel;

    adcoc_fifo #(
        .WIDTH (DATA_W + 1),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .clk_in        (ref_clk_in),
        .rst_in        (sys_rst_in),
        .ce_in         (clk_en_in),
        .in_valid_in   (smp_valid_in),
        .in_ready_out  (smp_ready_out),
        .in_data_in    ({smp_overrange_in, smp_data_in}),
        .out_valid_out (f_valid),
        .out_ready_in  (f_ready),
        .out_data_out  (f_data)
    );

    assign f_ready    = ~out_valid_out | out_ready_in;
    assign tp_sel     = format_reg[`ADCOC_F_TP_HI:`ADCOC_F_TP_LO];
    assign signed_sel = format_reg[`ADCOC_F_SIGNED]
                        & ~format_reg[`ADCOC_F_ABP];

    always @* begin
        // offset binary in; flip msb for two's complement, but only while abp is off
        coded = f_data[DATA_W-1:0];
        if (signed_sel)
            coded[DATA_W-1] = ~coded[DATA_W-1];
        // randomizer: xor upper bits with lsb (decodable by receiver)
        if (format_reg[`ADCOC_F_OUTPUT_RANDOMIZER_ON])
            coded[DATA_W-1:1] = coded[DATA_W-1:1]
                                ^ {(DATA_W-1){coded[0]}};
        // abp: invert every other bit on alternate samples
        if (format_reg[`ADCOC_F_ABP] && alt_reg)
            coded = coded ^ {(DATA_W/2){2'b10}};
        case (tp_sel)
            `ADCOC_TP_ZERO:  pat = {(DATA_W+1){1'b0}};
            `ADCOC_TP_ONE:   pat = {(DATA_W+1){1'b1}};
            `ADCOC_TP_CHECK: pat = alt_reg ? `ADCOC_CHECK_B
                                           : `ADCOC_CHECK_A;
            `ADCOC_TP_ALT:   pat = {(DATA_W+1){alt_reg}};
            default:         pat = {f_data[DATA_W], coded};
        endcase
    end

    always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            out_valid_out      <= 1'b0;
            out_data_out       <= {DATA_W{1'b0}};
            overrange_flag_out <= 1'b0;
            alt_reg            <= 1'b0;
            lfsr_reg           <= {DATA_W{1'b0}};
        end else if (clk_en_in) begin
            if (f_ready) begin
                out_valid_out <= f_valid;
                if (f_valid) begin
                    // settings sampled per word leaving the fifo
                    {overrange_flag_out, out_data_out} <= pat;
                    alt_reg <= ~alt_reg;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // driver configuration outputs
    always @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            output_clock_out                <= 1'b0;
            out_clock_delay_out             <= 2'h0;
            duty_cycle_stabilizer_on_out    <= 1'b0;
            output_format_sel_out           <= 2'h0;
            drive_current_code_out          <= 4'h0;
            internal_termination_enable_out <= 1'b0;
            out_data_oe_n_out               <= 1'b0;
            alternate_bit_polarity_out      <= 1'b0;
            output_randomizer_on_out        <= 1'b0;
        end else if (clk_en_in) begin
            // clock out toggles with each sample, polarity applied
            output_clock_out <= alt_reg
                                ^ timing_reg[`ADCOC_T_POL];
            out_clock_delay_out <=
                timing_reg[`ADCOC_T_PH_HI:`ADCOC_T_PH_LO];
            duty_cycle_stabilizer_on_out <= timing_reg[`ADCOC_T_DCS];
            output_format_sel_out <=
                mode_reg[`ADCOC_M_FMT_HI:`ADCOC_M_FMT_LO];
            // msb of code is the doubling set by termination
            drive_current_code_out <= {mode_reg[`ADCOC_M_TERM],
                mode_reg[`ADCOC_M_CUR_HI:`ADCOC_M_CUR_LO]};
            internal_termination_enable_out <=
                mode_reg[`ADCOC_M_TERM];
            out_data_oe_n_out <= mode_reg[`ADCOC_M_OFF];
            alternate_bit_polarity_out <= format_reg[`ADCOC_F_ABP];
            output_randomizer_on_out   <= format_reg[`ADCOC_F_OUTPUT_RANDOMIZER_ON];
        end
    end
endmodule // adcoc_regs

/* sim/adcoc_regs_chk.sv */
`timescale 1ns/1ns
module adcoc_regs_chk #(
    parameter DATA_W = 16
) (
    // clock and reset
    input logic              ref_clk_in,
    input logic              sys_rst_in,
    input logic              clk_en_in,
    // serial port
    input logic              ser_cs_n_in,
    input logic              ser_clk_in,
    input logic              ser_data_in,
    input logic              ser_data_out,
    input logic              ser_data_oe_n_out,
    // sample stream
    input logic              smp_valid_in,
    input logic              smp_ready_out,
    input logic              smp_overrange_in,
    input logic [DATA_W-1:0] smp_data_in,
    input logic [DATA_W-1:0] out_data_out,
    input logic              out_valid_out,
    input logic              out_ready_in,
    input logic              overrange_flag_out,
    input logic              out_data_oe_n_out,
    // driver configuration
    input logic              output_clock_out,
    input logic              duty_cycle_stabilizer_on_out,
    input logic [1:0]        out_clock_delay_out,
    input logic [1:0]        output_format_sel_out,
    input logic [3:0]        drive_current_code_out,
    input logic              internal_termination_enable_out,
    input logic              alternate_bit_polarity_out,
    input logic              output_randomizer_on_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence frame_start_s;
        $fell(ser_cs_n_in);
    endsequence
    sequence push_s;
        smp_valid_in && smp_ready_out;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    // serial output stays released for eight clocks after select falls
    sdo_quiet_a: assert property (
        frame_start_s |-> ser_data_oe_n_out [*8])
        else $error("serial output driven too early in a frame");
    sdo_idle_a: assert property (
        ser_cs_n_in [*4] |-> ser_data_oe_n_out)
        else $error("serial output driven outside a frame");
    sdo_level_a: assert property (
        !ser_data_oe_n_out |-> !ser_data_out)
        else $error("open drain output drives high");
    term_double_a: assert property (
        internal_termination_enable_out == drive_current_code_out[3])
        else $error("termination and doubled current disagree");
    out_hold_a: assert property (out_valid_out && !out_ready_in |=>
        out_valid_out && $stable(out_data_out) && $stable(overrange_flag_out))
        else $error("output word changed while stalled");
    push_out_a: assert property (push_s |-> ##[1:4] out_valid_out)
        else $error("accepted sample did not reach the output");
    full_hold_a: assert property (!smp_ready_out && out_valid_out
        && !out_ready_in |=> !smp_ready_out)
        else $error("full buffer accepted while output stalled");
    // settings move only through a serial write
    cfg_stable_a: assert property (
        ser_cs_n_in [*8] |=> $stable({
        out_clock_delay_out, duty_cycle_stabilizer_on_out,
        output_format_sel_out, drive_current_code_out, out_data_oe_n_out,
        alternate_bit_polarity_out, output_randomizer_on_out}))
        else $error("configuration changed with no serial write");
endmodule // adcoc_regs_chk
bind adcoc_regs adcoc_regs_chk #(.DATA_W(DATA_W)) u_adcoc_regs_chk (.*);

/* sim/adcoc_host.sv */
`timescale 1ns/1ns
module adcoc_host (
    // serial pins toward the device
    output logic ser_cs_n_out,
    output logic ser_clk_out,
    output logic ser_data_out,
    input  logic ser_wire_in
);
    initial begin
        ser_cs_n_out = 1'b1;
        ser_clk_out  = 1'b0;
        ser_data_out = 1'b0;
    end
    // clock stands low between frames; extra rises test the 16 edge limit
    task automatic xfer(input logic [15:0] word, input int extra,
                        output logic [7:0] rd);
        int i;
        rd = 8'h00;
        ser_cs_n_out = 1'b0;
        #62;
        for (i = 0; i < 16 + extra; i++) begin
            ser_data_out = (i < 16) ? word[15-i] : ~ser_data_out;
            #62;
            if (i >= 8 && i < 16)
                rd = {rd[6:0], ser_wire_in};
            ser_clk_out = 1'b1;
            #63;
            ser_clk_out = 1'b0;
        end
        #62;
        ser_cs_n_out = 1'b1;
        // a released line must not look like the last bit
        ser_data_out = ~ser_data_out;
        #100;
    endtask
endmodule // adcoc_host

/* sim/adcoc_regs_tb.sv */
`timescale 1ns/1ns
module adcoc_regs_tb;
    logic        ref_clk_in, sys_rst_in, clk_en_in;
    logic        ser_cs_n_in, ser_clk_in, ser_data_in;
    logic        ser_data_out, ser_data_oe_n_out;
    logic        smp_valid_in, smp_ready_out, smp_overrange_in;
    logic [15:0] smp_data_in, out_data_out;
    logic        out_valid_out, out_ready_in;
    logic        overrange_flag_out, out_data_oe_n_out;
    logic        output_clock_out, duty_cycle_stabilizer_on_out;
    logic [1:0]  out_clock_delay_out, output_format_sel_out;
    logic [3:0]  drive_current_code_out;
    logic        internal_termination_enable_out;
    logic        alternate_bit_polarity_out, output_randomizer_on_out;
    int          miscompares, check_count, k;
    logic [7:0]  rd, m;
    logic [16:0] w0, w1;
    logic        oc;
    logic [16:0] pat_a [4] = '{17'h00000, 17'h1FFFF, 17'h15555, 17'h00000};
    logic [16:0] pat_b [4] = '{17'h00000, 17'h1FFFF, 17'h0AAAA, 17'h1FFFF};
    // open drain line with its pull-up
    wire         ser_wire = ser_data_oe_n_out ? 1'b1 : ser_data_out;
    adcoc_regs u_adcoc_regs (.*);
    adcoc_host u_adcoc_host (.ser_cs_n_out(ser_cs_n_in),
        .ser_clk_out(ser_clk_in), .ser_data_out(ser_data_in),
        .ser_wire_in(ser_wire));
    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [16:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic timeout();
        check("wait_bound", 17'h1, 17'h0);
        finish_test();
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_adcoc_host.xfer({1'b0, a, d}, 0, rd);
    endtask
    // data bits of a read command are junk on purpose
    task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
        u_adcoc_host.xfer({1'b1, a, 8'hA5}, 0, rd);
        check("readback", rd, e);
    endtask
    task automatic push(input logic [16:0] v);
        int n;
        @(posedge ref_clk_in);
        smp_valid_in <= 1'b1;
        {smp_overrange_in, smp_data_in} <= v;
        for (n = 0; n < 64; n++) begin
            @(negedge ref_clk_in);
            if (smp_ready_out === 1'b1) break;
        end
        if (n == 64) timeout();
        @(posedge ref_clk_in);
        smp_valid_in <= 1'b0;
    endtask
    task automatic pop(output logic [16:0] v);
        int n;
        @(posedge ref_clk_in);
        out_ready_in <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(negedge ref_clk_in);
            if (out_valid_out === 1'b1) break;
        end
        if (n == 64) timeout();
        v = {overrange_flag_out, out_data_out};
        @(posedge ref_clk_in);
        out_ready_in <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        sys_rst_in = 1'b1;
        clk_en_in = 1'b1;
        smp_valid_in = 1'b0;
        smp_data_in = 16'h0000;
        smp_overrange_in = 1'b0;
        out_ready_in = 1'b0;
        miscompares = 0;
        check_count = 0;
        repeat (3) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        repeat (5) @(posedge ref_clk_in);
        for (int a = 2; a < 5; a++) rdchk(a[6:0], 8'h00);
        // stabilizer goes on with every nonzero delay
        for (int p = 0; p < 4; p++) begin
            wr(7'h02, {4'hF, 1'b0, p[1:0], p != 0});
            check("clock_delay", out_clock_delay_out, p[1:0]);
            check("stabilizer", duty_cycle_stabilizer_on_out,
                  p != 0);
        end
        oc = output_clock_out;
        wr(7'h02, 8'hFF);
        check("clock_polarity", output_clock_out, {~oc});
        rdchk(7'h02, 8'h0F);
        for (int i = 0; i < 8; i++) begin
            m = {1'b1, i[2:0], i[0], i[1], (i[1:0] == 2'h3) ? 2'h2 : i[1:0]};
            wr(7'h03, m);
            rdchk(7'h03, m & 8'h7F);
            check("drive_current", drive_current_code_out,
                  {i[0], i[2:0]});
            check("termination",
                  internal_termination_enable_out, i[0]);
            check("data_disable", out_data_oe_n_out, i[1]);
            check("format_sel", output_format_sel_out, m[1:0]);
        end
        wr(7'h01, 8'h02);
        rdchk(7'h01, 8'h00);
        u_adcoc_host.xfer({1'b0, 7'h04, 8'h01}, 3, rd);
        rdchk(7'h04, 8'h01);
        wr(7'h00, 8'h80);
        for (int a = 2; a < 5; a++) rdchk(a[6:0], 8'h00);
        check("current_cleared", drive_current_code_out, 4'h0);
        push(17'h11234);
        pop(w0);
        check("plain_word", w0, 17'h11234);
        wr(7'h04, 8'h01);
        push(17'h01234);
        pop(w0);
        check("signed_word", w0, 17'h09234);
        wr(7'h04, 8'h02);
        check("randomizer_on", output_randomizer_on_out, 1'b1);
        push(17'h01235);
        pop(w0);
        check("random_word", w0, 17'h0EDCB);
        wr(7'h04, 8'h05);
        check("abp_on", alternate_bit_polarity_out, 1'b1);
        push(17'h01234);
        push(17'h01234);
        pop(w0);
        pop(w1);
        check("abp_pair", w0 ^ w1, 17'h0AAAA);
        check("abp_word",
              w0 === 17'h01234 || w0 === 17'h0B89E, 1'b1);
        for (int t = 0; t < 4; t++) begin
            wr(7'h04, {2'h3, t[1:0], 1'b1, 3'h0});
            push(17'h01234);
            push(17'h01234);
            pop(w0);
            pop(w1);
            check("pattern_first",
                  w0 === pat_a[t] || w0 === pat_b[t], 1'b1);
            check("pattern_next", w1,
                  (w0 === pat_a[t]) ? pat_b[t] : pat_a[t]);
        end
        // fill with the consumer stalled, then drain in order
        wr(7'h04, 8'h00);
        for (k = 0; k < 8; k++) begin
            @(negedge ref_clk_in);
            if (smp_ready_out !== 1'b1) break;
            push(17'(k));
        end
        // four in the buffer plus one held in the output stage
        check("fifo_depth", 17'(k), 17'h5);
        // frozen with the consumer ready: nothing may move
        @(posedge ref_clk_in);
        clk_en_in <= 1'b0;
        out_ready_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        clk_en_in <= 1'b1;
        out_ready_in <= 1'b0;
        @(negedge ref_clk_in);
        check("frozen_full", smp_ready_out, 1'b0);
        for (int j = 0; j < k; j++) begin
            pop(w0);
            check("drain_order", w0, 17'(j));
        end
        @(negedge ref_clk_in);
        check("drained", out_valid_out, 1'b0);
        finish_test();
    end
endmodule // adcoc_regs_tb
